/* verilog/mit_top.sv */
// Interrupt aggregation and thermal alarm with AXI4-Lite registers
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mit_params.svh"
module mit_top #(
  parameter int N_FANS  = 8,
  parameter int N_GPIO  = 16
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Measurements
  input  wire mit_pkg::mit_meas_type temp_meas,
  input  wire logic                  fan_valid,
  input  wire logic [2:0]            fan_chan,
  input  wire logic [7:0]            fan_count,
  input  wire logic                  fan_cycle_done,
  // SMBus alert response address seen
  input  wire logic                  ara_seen,
  input  wire logic [6:0]            ara_addr,
  // GPIO and intrusion
  input  wire logic [N_GPIO-1:0]     gpio_in,
  input  wire logic [N_GPIO-1:0]     gpio_dir_out,
  input  wire logic [N_GPIO-1:0]     gpio_pol,
  input  wire logic                  chassis_intrusion,
  // Shared pin
  input  wire logic                  shared_pin_sixteen_io_in,
  output logic                       thermal_alarm_n_out,
  output logic                       thermal_alarm_n_oe_n,
  // Outputs
  output logic                       int_n,
  output logic                       fan_full_scale
);
  import mit_pkg::*;

  // ==========================================================
  // Registers
  logic [7:0]        cfg1_q, cfg3_q, mask4_q, fanlim_q;
  logic [N_FANS-1:0] mask3_q;
  logic [N_GPIO-1:0] maskg_q;
  logic [23:0]       thlim_q;
  logic              st4_thermal_alarm_n_q, ci_q;
  logic              thermal_alarm_n_evt_q, thermal_alarm_n_prev_q;
  logic [7:0]        st1_q;
  logic [N_FANS-1:0] fan_status;
  logic              fan_latch, over, exceed;
  logic              int_clear;
  logic              stat1_read;
  mit_axst_type      wst_q, rst_q;
  logic              aw_q, w_q;
  logic [7:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              wr_go;
  logic [N_GPIO-1:0] gpio_stat;
  logic              g16_stat;
  logic [7:0]        stat4_v;
  logic              alarm_act;
  logic              ext_low;

  // Write on byte lane 0 only when strobed
  function automatic logic [7:0] mit_wb(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    mit_wb = s[0] ? d[7:0] : old;
  endfunction : mit_wb

  // ==========================================================
  // Sub blocks
  mit_thermal u_thermal (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .temp_meas    (temp_meas),
    .thermal_alarm_n_limits (thlim_q),
    .over_q       (over),
    .exceed_q     (exceed)
  );

  mit_fan #(.N_FANS(N_FANS)) u_fan (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .fan_valid      (fan_valid),
    .fan_chan       (fan_chan),
    .fan_count      (fan_count),
    .fan_cycle_done (fan_cycle_done),
    .fan_limit      (fanlim_q),
    .fan_mask       (mask3_q),
    .int_clear      (int_clear),
    .fan_status_q   (fan_status),
    .fan_latch_q    (fan_latch)
  );

  // ==========================================================
  // AXI4-Lite write channel
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q          <= 1'b0;
      w_q           <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      wst_q         <= MIT_AX_IDLE;
    end else begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      unique case (wst_q)
        MIT_AX_IDLE: begin
          if (wr_go) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'h0;
            wst_q        <= MIT_AX_RESP;
          end
        end
        MIT_AX_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wst_q        <= MIT_AX_IDLE;
          end
        end
      endcase
    end
  end

  // Register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg1_q   <= `MIT_CFG1_RST;
      cfg3_q   <= `MIT_CFG3_RST;
      thlim_q  <= {3{`MIT_THLIM_RST}};
      mask3_q  <= '0;
      mask4_q  <= `MIT_MASK_RST;
      maskg_q  <= '0;
      fanlim_q <= `MIT_FANLIM_RST;
    end else if (wr_go) begin
      unique case (awaddr_q)
        `MIT_CFG1_OFF:   cfg1_q <= mit_wb(cfg1_q, wdata_q, wstrb_q);
        `MIT_CFG3_OFF:   cfg3_q <= mit_wb(cfg3_q, wdata_q, wstrb_q);
        `MIT_THLIM0_OFF: thlim_q[7:0] <= mit_wb(thlim_q[7:0], wdata_q, wstrb_q);
        `MIT_THLIM1_OFF: thlim_q[15:8] <= mit_wb(thlim_q[15:8], wdata_q, wstrb_q);
        `MIT_THLIM2_OFF: thlim_q[23:16] <= mit_wb(thlim_q[23:16], wdata_q, wstrb_q);
        `MIT_MASK3_OFF:  mask3_q <= N_FANS'(mit_wb(8'(mask3_q), wdata_q, wstrb_q));
        `MIT_MASK4_OFF:  mask4_q <= mit_wb(mask4_q, wdata_q, wstrb_q);
        `MIT_MASKG_OFF:  maskg_q <= N_GPIO'(wdata_q);
        `MIT_FANLIM_OFF: fanlim_q <= mit_wb(fanlim_q, wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  assign stat1_read = s_axi_arvalid && s_axi_arready && s_axi_araddr == `MIT_STAT1_OFF;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
      rst_q         <= MIT_AX_IDLE;
    end else begin
      unique case (rst_q)
        MIT_AX_IDLE: begin
          s_axi_arready <= s_axi_arvalid && !s_axi_arready;
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            rst_q         <= MIT_AX_RESP;
            unique case (s_axi_araddr)
              `MIT_CFG1_OFF:   s_axi_rdata <= {24'h0, cfg1_q};
              `MIT_CFG3_OFF:   s_axi_rdata <= {24'h0, cfg3_q};
              `MIT_THLIM0_OFF: s_axi_rdata <= {24'h0, thlim_q[7:0]};
              `MIT_THLIM1_OFF: s_axi_rdata <= {24'h0, thlim_q[15:8]};
              `MIT_THLIM2_OFF: s_axi_rdata <= {24'h0, thlim_q[23:16]};
              `MIT_MASK3_OFF:  s_axi_rdata <= 32'(mask3_q);
              `MIT_MASK4_OFF:  s_axi_rdata <= {24'h0, mask4_q};
              `MIT_MASKG_OFF:  s_axi_rdata <= 32'(maskg_q);
              `MIT_STAT1_OFF:  s_axi_rdata <= {24'h0, st1_q};
              `MIT_STAT3_OFF:  s_axi_rdata <= 32'(fan_status);
              `MIT_STAT4_OFF:  s_axi_rdata <= {24'h0, stat4_v};
              `MIT_STATG_OFF:  s_axi_rdata <= 32'(gpio_stat);
              `MIT_FANLIM_OFF: s_axi_rdata <= {24'h0, fanlim_q};
              default: begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'h2;
              end
            endcase
          end
        end
        MIT_AX_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rst_q        <= MIT_AX_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // GPIO, intrusion and status
  always_comb begin
    gpio_stat = ~(gpio_in ^ gpio_pol) & ~gpio_dir_out;
    g16_stat  = cfg3_q[`MIT_CFG3_GPIOMODE] &&
                (shared_pin_sixteen_io_in == cfg3_q[`MIT_CFG3_G16POL]);
    stat4_v   = 8'h00;
    stat4_v[`MIT_ST4_G16]   = g16_stat;
    stat4_v[`MIT_ST4_CI]    = ci_q;
    stat4_v[`MIT_ST4_THERMAL_ALARM_N] = st4_thermal_alarm_n_q;
  end

  // Intrusion latch, cleared by its own clear bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ci_q <= 1'b0;
    end else if (chassis_intrusion) begin
      ci_q <= 1'b1;
    end else if (cfg3_q[`MIT_CFG3_CICLR]) begin
      ci_q <= 1'b0;
    end
  end

  // Status one shadow holds the overall thermal over level, refreshed every cycle, not cleared on read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st1_q <= 8'h00;
    end else begin
      st1_q <= {7'h0, over};
    end
  end

  // Thermal status bit; set wins over the read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st4_thermal_alarm_n_q <= 1'b0;
    end else if (exceed) begin
      st4_thermal_alarm_n_q <= 1'b1;
    end else if (stat1_read) begin
      st4_thermal_alarm_n_q <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt clear sources
  assign int_clear = stat1_read
                   || (ara_seen && ara_addr == `MIT_ARA_ADDR)
                   || cfg1_q[`MIT_CFG1_INTCLR];

  // Thermal change event, one-off until cleared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thermal_alarm_n_prev_q <= 1'b0;
      thermal_alarm_n_evt_q  <= 1'b0;
    end else begin
      thermal_alarm_n_prev_q <= alarm_act;
      if (alarm_act != thermal_alarm_n_prev_q)
        thermal_alarm_n_evt_q <= 1'b1;
      else if (int_clear)
        thermal_alarm_n_evt_q <= 1'b0;
    end
  end

  // ==========================================================
  // Alarm pin and full scale forcing
  always_comb begin
    alarm_act = over && cfg1_q[`MIT_CFG1_THEN] && !cfg3_q[`MIT_CFG3_GPIOMODE];
    ext_low   = !cfg3_q[`MIT_CFG3_GPIOMODE] && !shared_pin_sixteen_io_in;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thermal_alarm_n_out  <= 1'b1;
      thermal_alarm_n_oe_n <= 1'b1;
      fan_full_scale       <= 1'b0;
    end else begin
      thermal_alarm_n_out  <= 1'b0;
      thermal_alarm_n_oe_n <= !alarm_act;
      fan_full_scale       <= alarm_act || ext_low;
    end
  end

  // ==========================================================
  // Interrupt output, active low
  logic unl_src;
  always_comb begin
    unl_src = |(gpio_stat & ~maskg_q & ~gpio_dir_out)
            || (g16_stat && !mask4_q[`MIT_ST4_G16])
            || (ci_q && !mask4_q[`MIT_ST4_CI]);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_n <= 1'b1;
    end else begin
      int_n <= !(cfg1_q[`MIT_CFG1_INTEN] && !cfg1_q[`MIT_CFG1_INTCLR] &&
                 (fan_latch || thermal_alarm_n_evt_q || unl_src));
    end
  end
endmodule : mit_top
`default_nettype wire

/* verilog/mit_params.svh */
// Register offsets, field positions, reset values and constants of the interrupt block
`ifndef MIT_PARAMS_SVH
`define MIT_PARAMS_SVH
// ==========================================================
// Register byte offsets
`define MIT_CFG1_OFF      8'h00
`define MIT_CFG3_OFF      8'h1c
`define MIT_THLIM0_OFF    8'h34
`define MIT_THLIM1_OFF    8'h38
`define MIT_THLIM2_OFF    8'h3c
`define MIT_MASK3_OFF     8'h68
`define MIT_MASK4_OFF     8'h6c
`define MIT_MASKG_OFF     8'h70
`define MIT_STAT1_OFF     8'h74
`define MIT_STAT3_OFF     8'h78
`define MIT_STAT4_OFF     8'h8c
`define MIT_STATG_OFF     8'h90
`define MIT_FANLIM_OFF    8'h94
`define MIT_GPIOCFG_OFF   8'h98
// ==========================================================
// Field positions
`define MIT_CFG1_INTEN    1
`define MIT_CFG1_INTCLR   2
`define MIT_CFG1_THEN     4
`define MIT_CFG3_GPIOMODE 0
`define MIT_CFG3_CICLR    1
`define MIT_CFG3_G16DIR   6
`define MIT_CFG3_G16POL   7
`define MIT_ST4_THERMAL_ALARM_N     3
`define MIT_ST4_CI        6
`define MIT_ST4_G16       7
// ==========================================================
// Reset values and constants
`define MIT_CFG1_RST      8'h00
`define MIT_CFG3_RST      8'h00
`define MIT_THLIM_RST     8'h50
`define MIT_FANLIM_RST    8'hff
`define MIT_MASK_RST      8'h00
`define MIT_HYST_C        8'h05
`define MIT_ARA_ADDR      7'h0c
`endif

/* verilog/mit_pkg.sv */
// Types shared by the interrupt and thermal alarm block
`default_nettype none
package mit_pkg;
  // One temperature measurement result
  typedef struct packed {
    logic       valid;
    logic [1:0] chan;
    logic [7:0] value;
  } mit_meas_type;
  // Thermal alarm pin, three signals
  typedef struct packed {
    logic in;
    logic out;
    logic oe_n;
  } mit_pin_type;
  typedef enum logic [1:0] {MIT_AX_IDLE, MIT_AX_RESP} mit_axst_type;
endpackage : mit_pkg
`default_nettype wire

/* verilog/mit_thermal.sv */
// Thermal limit comparison with fixed hysteresis
`timescale 1ns/1ps
`default_nettype none
`include "mit_params.svh"
module mit_thermal (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Measurements and limits
  input  wire mit_pkg::mit_meas_type temp_meas,
  input  wire logic [23:0]           thermal_alarm_n_limits,
  // Alarm state
  output logic                       over_q,
  output logic                       exceed_q
);
  import mit_pkg::*;
  logic [2:0] hot_q;
  logic [7:0] lim;
  always_comb begin
    lim = thermal_alarm_n_limits[8*temp_meas.chan +: 8];
  end
  // Per channel hot flags with hysteresis
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hot_q <= 3'h0;
    end else if (temp_meas.valid && temp_meas.chan != 2'h3) begin
      if (temp_meas.value > lim)
        hot_q[temp_meas.chan] <= 1'b1;
      else if ({1'b0, temp_meas.value} + {1'b0, `MIT_HYST_C} <= {1'b0, lim})
        hot_q[temp_meas.chan] <= 1'b0;
    end
  end
  // Exceed pulse and overall alarm level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      over_q   <= 1'b0;
      exceed_q <= 1'b0;
    end else begin
      over_q   <= |hot_q;
      exceed_q <= temp_meas.valid && temp_meas.chan != 2'h3 && temp_meas.value > lim;
    end
  end
endmodule : mit_thermal
`default_nettype wire

/* verilog/mit_fan.sv */
// Fan underspeed status and fan interrupt latch
`timescale 1ns/1ps
`default_nettype none
module mit_fan #(
  parameter int N_FANS = 8
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Measurement
  input  wire logic              fan_valid,
  input  wire logic [2:0]        fan_chan,
  input  wire logic [7:0]        fan_count,
  input  wire logic              fan_cycle_done,
  input  wire logic [7:0]        fan_limit,
  input  wire logic [N_FANS-1:0] fan_mask,
  input  wire logic              int_clear,
  // Results
  output logic [N_FANS-1:0]      fan_status_q,
  output logic                   fan_latch_q
);
  logic hold_q;
  // Status set for underspeed, cleared otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fan_status_q <= '0;
    end else if (fan_valid) begin
      fan_status_q[fan_chan] <= fan_count > fan_limit;
    end
  end
  // Blocking after clear until the next cycle ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_q <= 1'b0;
    end else if (int_clear) begin
      hold_q <= 1'b1;
    end else if (fan_cycle_done) begin
      hold_q <= 1'b0;
    end
  end
  // Latch of unmasked status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fan_latch_q <= 1'b0;
    end else if (int_clear) begin
      fan_latch_q <= 1'b0;
    end else if (!hold_q && |(fan_status_q & ~fan_mask)) begin
      fan_latch_q <= 1'b1;
    end
  end
endmodule : mit_fan
`default_nettype wire

/* tb/mit_properties.sv */
// Port-level checks of the interrupt and thermal alarm block
`timescale 1ns/1ps
`default_nettype none
module mit_properties (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Events and pins
  input wire logic        ara_seen,
  input wire logic [6:0]  ara_addr,
  input wire logic        chassis_intrusion,
  input wire logic        shared_pin_sixteen_io_in,
  input wire logic        thermal_alarm_n_out,
  input wire logic        thermal_alarm_n_oe_n,
  input wire logic        int_n,
  input wire logic        fan_full_scale
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Alarm pin and fan forcing
  property p_rst_idle;
    disable iff (1'b0) !aresetn |=> int_n && thermal_alarm_n_oe_n && !fan_full_scale;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle in reset");
  property p_pin_low;
    !thermal_alarm_n_oe_n |-> !thermal_alarm_n_out;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("alarm pin driven high");
  property p_alarm_full;
    !thermal_alarm_n_oe_n [*3] |-> fan_full_scale;
  endproperty
  a_alarm_full: assert property (p_alarm_full) else $error("alarm without full scale");
  property p_full_cause;
    $rose(fan_full_scale) |-> !shared_pin_sixteen_io_in || !$past(shared_pin_sixteen_io_in)
      || !$past(shared_pin_sixteen_io_in, 2);
  endproperty
  a_full_cause: assert property (p_full_cause) else $error("full scale without low pin");
  // ==========================================================
  // Interrupt clearing by alert response
  property p_ara_clr;
    ara_seen && ara_addr == 7'h0c && !chassis_intrusion |-> ##[1:3] int_n;
  endproperty
  a_ara_clr: assert property (p_ara_clr) else $error("alert response left int low");
  property p_ara_other;
    ara_seen && ara_addr != 7'h0c && !int_n |=> !int_n;
  endproperty
  a_ara_other: assert property (p_ara_other) else $error("wrong address cleared int");
  // ==========================================================
  // Register bus answers
  property p_r_after_ar;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after_ar: assert property (p_r_after_ar) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read returned data");
endmodule : mit_properties
bind mit_top mit_properties i_props (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .ara_seen, .ara_addr,
  .chassis_intrusion, .shared_pin_sixteen_io_in, .thermal_alarm_n_out,
  .thermal_alarm_n_oe_n, .int_n, .fan_full_scale
);
`default_nettype wire

/* tb/mit_pin_model.sv */
// Pulled-up alarm wire shared with an outside party
`timescale 1ns/1ps
`default_nettype none
module mit_pin_model (
  // Device side
  input  wire logic thermal_alarm_n_out,
  input  wire logic thermal_alarm_n_oe_n,
  // Outside party pulling low
  input  wire logic ext_pull_low,
  // Resolved level
  output logic      pin_level
);
  // Pull-up wins unless someone pulls low
  assign pin_level = !(ext_pull_low || (!thermal_alarm_n_oe_n && !thermal_alarm_n_out));
endmodule : mit_pin_model
`default_nettype wire

/* tb/mit_top_tb.sv */
// Self-checking bench of the interrupt and thermal alarm block
`timescale 1ns/1ps
`default_nettype none
`include "mit_params.svh"
module mit_top_tb;
  import mit_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, fan_valid, fan_cycle_done, ara_seen, chassis_intrusion;
  logic ext_low, pin, thermal_alarm_n_out, thermal_alarm_n_oe_n, int_n, fan_full_scale;
  logic [7:0] s_axi_awaddr, s_axi_araddr, fan_count;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [2:0] fan_chan;
  logic [6:0] ara_addr;
  logic [15:0] gpio_in, gpio_dir_out, gpio_pol;
  mit_meas_type temp_meas;
  int n_mismatch, num_checks, cyc_n;
  // ==========================================================
  // Design and far side
  mit_top i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .temp_meas, .fan_valid, .fan_chan,
    .fan_count, .fan_cycle_done, .ara_seen, .ara_addr, .gpio_in, .gpio_dir_out,
    .gpio_pol, .chassis_intrusion, .shared_pin_sixteen_io_in(pin),
    .thermal_alarm_n_out, .thermal_alarm_n_oe_n, .int_n, .fan_full_scale
  );
  mit_pin_model i_pin (
    .thermal_alarm_n_out, .thermal_alarm_n_oe_n, .ext_pull_low(ext_low), .pin_level(pin)
  );
  // Clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Hang guard
  always @(posedge aclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      n_mismatch++;
      results();
    end
  end
  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1 && !aw) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1 && !w) s_axi_wvalid <= 1'b0;
      aw = aw | (s_axi_awready === 1'b1);
      w = w | (s_axi_wready === 1'b1);
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    chk("bresp", 32'h0, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
    cyc(2);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    cyc(2);
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd(a);
    chk($sformatf("reg %h", a), e, rv & m);
  endtask : rdc
  task automatic temp(input logic [1:0] c, input logic [7:0] v);
    @(posedge aclk);
    temp_meas <= '{1'b1, c, v};
    @(posedge aclk);
    temp_meas.valid <= 1'b0;
    cyc(4);
  endtask : temp
  task automatic fan(input logic [2:0] c, input logic [7:0] v, input logic dn);
    @(posedge aclk);
    fan_cycle_done <= dn;
    fan_valid <= !dn;
    fan_chan <= c;
    fan_count <= v;
    @(posedge aclk);
    fan_valid <= 1'b0;
    fan_cycle_done <= 1'b0;
    cyc(4);
  endtask : fan
  task automatic ara(input logic [6:0] a);
    @(posedge aclk);
    ara_seen <= 1'b1;
    ara_addr <= a;
    @(posedge aclk);
    ara_seen <= 1'b0;
    cyc(4);
  endtask : ara
  task automatic st(input logic oe, input logic fs, input logic it);
    chk("oe_n", oe, thermal_alarm_n_oe_n);
    chk("full", fs, fan_full_scale);
    chk("int_n", it, int_n);
    chk("pin", oe, pin);
  endtask : st
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask : tend
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  // ==========================================================
  // Sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, fan_valid, fan_cycle_done, ara_seen, chassis_intrusion, ext_low} = '0;
    {s_axi_awaddr, s_axi_araddr, fan_count, s_axi_wdata, fan_chan, ara_addr} = '0;
    {gpio_in, gpio_dir_out, n_mismatch, num_checks, cyc_n} = '0;
    s_axi_wstrb = 4'hf;
    gpio_pol = 16'hffff;
    temp_meas = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`MIT_CFG1_OFF, `MIT_CFG1_RST, 32'hff);
    rdc(`MIT_THLIM2_OFF, `MIT_THLIM_RST, 32'hff);
    rdc(`MIT_FANLIM_OFF, `MIT_FANLIM_RST, 32'hff);
    rd(8'h04);
    chk("bad resp", 32'h2, {30'h0, rr});
    st(1'b1, 1'b0, 1'b1);
    tend("reset");
    wr(`MIT_CFG1_OFF, 32'h02);
    temp(2'd0, 8'h51);
    st(1'b1, 1'b0, 1'b1);
    rdc(`MIT_STAT4_OFF, 32'h08, 32'h08);
    temp(2'd0, 8'h40);
    rdc(`MIT_STAT1_OFF, 32'h0, 32'hff);
    rdc(`MIT_STAT4_OFF, 32'h00, 32'h08);
    wr(`MIT_CFG1_OFF, 32'h12);
    temp(2'd2, 8'h51);
    st(1'b0, 1'b1, 1'b0);
    rdc(`MIT_STAT1_OFF, 32'h1, 32'hff);
    temp(2'd2, 8'h4c);
    st(1'b0, 1'b1, 1'b1);
    temp(2'd2, 8'h4b);
    st(1'b1, 1'b0, 1'b0);
    wr(`MIT_CFG1_OFF, 32'h16);
    st(1'b1, 1'b0, 1'b1);
    wr(`MIT_CFG1_OFF, 32'h12);
    st(1'b1, 1'b0, 1'b1);
    tend("thermal");
    @(posedge aclk);
    ext_low <= 1'b1;
    cyc(4);
    chk("full", 1'b1, fan_full_scale);
    wr(`MIT_CFG3_OFF, 32'h01);
    chk("full", 1'b0, fan_full_scale);
    rdc(`MIT_STAT4_OFF, 32'h80, 32'h80);
    chk("int_n", 1'b0, int_n);
    wr(`MIT_MASK4_OFF, 32'h80);
    chk("int_n", 1'b1, int_n);
    @(posedge aclk);
    ext_low <= 1'b0;
    wr(`MIT_CFG3_OFF, 32'h00);
    wr(`MIT_MASK4_OFF, 32'h00);
    tend("pin");
    wr(`MIT_FANLIM_OFF, 32'h80);
    rdc(`MIT_STAT1_OFF, 32'h0, 32'hff);
    fan(3'd0, 8'h00, 1'b1);
    fan(3'd3, 8'h80, 1'b0);
    chk("int_n", 1'b1, int_n);
    fan(3'd3, 8'h81, 1'b0);
    rdc(`MIT_STAT3_OFF, 32'h08, 32'hff);
    chk("int_n", 1'b0, int_n);
    ara(7'h0d);
    chk("int_n", 1'b0, int_n);
    ara(`MIT_ARA_ADDR);
    fan(3'd3, 8'h81, 1'b0);
    chk("int_n", 1'b1, int_n);
    fan(3'd0, 8'h00, 1'b1);
    fan(3'd3, 8'h81, 1'b0);
    chk("int_n", 1'b0, int_n);
    wr(`MIT_MASK3_OFF, 32'h08);
    rdc(`MIT_STAT1_OFF, 32'h0, 32'hff);
    fan(3'd0, 8'h00, 1'b1);
    fan(3'd3, 8'h81, 1'b0);
    chk("int_n", 1'b1, int_n);
    wr(`MIT_MASK3_OFF, 32'h00);
    fan(3'd3, 8'h10, 1'b0);
    rdc(`MIT_STAT3_OFF, 32'h00, 32'hff);
    tend("fan");
    @(posedge aclk);
    gpio_in <= 16'h0020;
    rdc(`MIT_STATG_OFF, 32'h20, 32'hffff);
    rdc(`MIT_STAT1_OFF, 32'h0, 32'hff);
    chk("int_n", 1'b0, int_n);
    wr(`MIT_MASKG_OFF, 32'h20);
    chk("int_n", 1'b1, int_n);
    wr(`MIT_MASKG_OFF, 32'h00);
    gpio_dir_out <= 16'h0020;
    cyc(4);
    chk("int_n", 1'b1, int_n);
    gpio_in <= 16'h0000;
    gpio_dir_out <= 16'h0000;
    chassis_intrusion <= 1'b1;
    rdc(`MIT_STAT4_OFF, 32'h40, 32'h40);
    chk("int_n", 1'b0, int_n);
    wr(`MIT_MASK4_OFF, 32'h40);
    chk("int_n", 1'b1, int_n);
    chassis_intrusion <= 1'b0;
    tend("gpio");
    results();
  end
endmodule : mit_top_tb
`default_nettype wire
